/* design/smrb_defs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SMRB_DEFS_SVH
`define SMRB_DEFS_SVH
`define SMRB_OFF_CFG 6'h00
`define SMRB_OFF_STAT 6'h01
`define SMRB_OFF_MASK 6'h03
`define SMRB_OFF_RATE 6'h07
`define SMRB_OFF_CHOFF 6'h08
`define SMRB_OFF_SHOT 6'h09
`define SMRB_OFF_SLEEP 6'h0a
`define SMRB_OFF_ADV 6'h0b
`define SMRB_OFF_BUSY 6'h0c
`define SMRB_OFF_RES_LO 6'h20
`define SMRB_OFF_RES_HI 6'h27
`define SMRB_OFF_LIM_LO 6'h2a
`define SMRB_OFF_LIM_HI 6'h39
`define SMRB_OFF_MAKER 6'h3e
`define SMRB_OFF_REV 6'h3f
`define SMRB_CFG_START 0
`define SMRB_CFG_AEN 1
`define SMRB_CFG_ACLR 3
`define SMRB_CFG_INIT 7
`define SMRB_CFG_WMASK 8'h8b
`define SMRB_RST_CFG 8'h08
`define SMRB_RST_BUSY 8'h02
`define SMRB_RST_ZERO 8'h00
`define SMRB_NCH 8
`define SMRB_NLIM 16
`define SMRB_CONV_NS 100
`define SMRB_CONV_CYC ((`SMRB_CONV_NS + 9) / 10)
`endif

/* design/smrb_pkg.sv */
// Types shared by the register bank modules.
package smrb_pkg;
    typedef logic [5:0] smrb_addr_t;
    typedef logic [7:0] smrb_byte_t;
    typedef logic [15:0] smrb_word_t;
    typedef enum logic [1:0] {
        SMRB_IDLE = 2'b00,
        SMRB_CONV = 2'b01,
        SMRB_NEXT = 2'b10
    } smrb_seq_e;
endpackage

/* design/smrb_res_if.sv */
// Result write path from the sequencer to the result store.
`timescale 1ns/1ps
interface smrb_res_if;
    logic we;
    logic [2:0] idx;
    logic [15:0] data;
    modport src (output we, output idx, output data);
    modport dst (input we, input idx, input data);
endinterface

/* design/smrb_results.sv */
// Store of the eight latest channel readings.
`timescale 1ns/1ps
`include "smrb_defs.svh"
module smrb_results
(
    input wire logic clk_i,
    input wire logic clr_i,
    smrb_res_if.dst wr,
    input wire logic [2:0] rd_idx_i,
    output logic [15:0] rd_data_o
);
    import smrb_pkg::*;
    smrb_word_t mem_reg [`SMRB_NCH];

    // One store slot per channel; restore and reset both clear it.
    genvar g;
    generate
        for (g = 0; g < `SMRB_NCH; g++)
        begin : g_slot
            always_ff @(posedge clk_i)
            begin
                if (clr_i)
                    mem_reg[g] <= 16'h0000;
                else if (wr.we && wr.idx == 3'(g))
                    mem_reg[g] <= wr.data;
            end
        end
    endgenerate

    assign rd_data_o = mem_reg[rd_idx_i];
endmodule

/* design/smrb_seq.sv */
// Round-robin channel sequencer with window comparison.
`timescale 1ns/1ps
`include "smrb_defs.svh"
module smrb_seq
(
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic run_i,
    input wire logic hold_i,
    input wire logic shot_i,
    input wire logic [7:0] off_i,
    input wire logic [7:0] lim_hi_i [`SMRB_NCH],
    input wire logic [7:0] lim_lo_i [`SMRB_NCH],
    input wire logic [15:0] sample_i [`SMRB_NCH],
    smrb_res_if.src res,
    output logic [7:0] err_o,
    output logic busy_o
);
    import smrb_pkg::*;
    localparam logic [7:0] CONV_CYC = 8'(`SMRB_CONV_CYC);
    smrb_seq_e state_reg;
    logic [2:0] ch_reg;
    logic [7:0] cnt_reg;
    logic oneshot_reg;
    logic [7:0] rd8;

    assign rd8 = sample_i[ch_reg][11:4];
    assign busy_o = (state_reg != SMRB_IDLE);

    // Walk the channels; hold stops the loop at the next boundary.
    always_ff @(posedge clk_i)
    begin
        if (clr_i)
        begin
            state_reg <= SMRB_IDLE;
            ch_reg <= 3'h0;
            cnt_reg <= 8'h00;
            oneshot_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                SMRB_IDLE:
                begin
                    ch_reg <= 3'h0;
                    cnt_reg <= 8'h00;
                    if (shot_i || (run_i && !hold_i))
                    begin
                        oneshot_reg <= shot_i;
                        state_reg <= SMRB_CONV;
                    end
                end
                SMRB_CONV:
                begin
                    if (off_i[ch_reg] || cnt_reg == CONV_CYC - 8'h01)
                        state_reg <= SMRB_NEXT;
                    else
                        cnt_reg <= cnt_reg + 8'h01;
                end
                SMRB_NEXT:
                begin
                    cnt_reg <= 8'h00;
                    ch_reg <= ch_reg + 3'h1;
                    if (ch_reg == 3'h7 && (oneshot_reg || hold_i))
                        state_reg <= SMRB_IDLE;
                    // Dropping start or raising clear ends the loop here.
                    else if ((hold_i || !run_i) && !oneshot_reg)
                        state_reg <= SMRB_IDLE;
                    else
                        state_reg <= SMRB_CONV;
                end
                default: state_reg <= SMRB_IDLE;
            endcase
        end
    end

    // Store a reading and compare it to its window when enabled.
    always_comb
    begin
        // Clear bit also blocks the store, so no new status flag can be set under it.
        res.we = (state_reg == SMRB_NEXT) && !off_i[ch_reg] && !hold_i;
        res.idx = ch_reg;
        res.data = sample_i[ch_reg];
        err_o = 8'h00;
        if (res.we && (rd8 > lim_hi_i[ch_reg] || rd8 <= lim_lo_i[ch_reg]))
            err_o[ch_reg] = 1'b1;
    end
endmodule

/* design/smrb_top.sv */
// Register bank of an eight-channel system monitor.
`timescale 1ns/1ps
`include "smrb_defs.svh"
module smrb_top
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] REV_CODE = 8'h3c // Arbitrary value.
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire smrb_pkg::smrb_addr_t addr_i,
    input wire smrb_pkg::smrb_byte_t wdata_i,
    output smrb_pkg::smrb_word_t rdata_o,
    input wire logic [15:0] sample_i [`SMRB_NCH],
    output logic alarm_n_o,
    output logic alarm_oe_n_o,
    output logic [7:0] rate_o,
    output logic deep_sleep_o,
    output logic [7:0] adv_mode_o
);
    import smrb_pkg::*;

    smrb_byte_t cfg_reg;
    smrb_byte_t stat_reg;
    smrb_byte_t mask_reg;
    smrb_byte_t rate_reg;
    smrb_byte_t off_reg;
    smrb_byte_t sleep_reg;
    smrb_byte_t adv_reg;
    smrb_byte_t lim_reg [`SMRB_NLIM];
    logic shot_pulse;
    logic clr_all;
    logic busy;
    logic stat_rd;
    logic not_ready_reg;
    logic [7:0] err;
    logic [7:0] lim_hi [`SMRB_NCH];
    logic [7:0] lim_lo [`SMRB_NCH];
    smrb_word_t res_word;
    smrb_word_t rdata_next;
    logic alarm_act;

    smrb_res_if res_bus ();

    // Restore acts as reset on all state but rdata_o and alarm_oe_n_o, which only reset forces.
    assign clr_all = sys_rst_i || cfg_reg[`SMRB_CFG_INIT];
    assign shot_pulse = wr_i && addr_i == `SMRB_OFF_SHOT;
    assign stat_rd = rd_i && addr_i == `SMRB_OFF_STAT;

    // Config holds only writable bits; init drops after one cycle.
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
            cfg_reg <= `SMRB_RST_CFG;
        else if (wr_i && addr_i == `SMRB_OFF_CFG)
            cfg_reg <= wdata_i & `SMRB_CFG_WMASK;
    end

    // Plain control registers that software writes freely.
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            mask_reg <= `SMRB_RST_ZERO;
            rate_reg <= `SMRB_RST_ZERO;
            off_reg <= `SMRB_RST_ZERO;
            sleep_reg <= `SMRB_RST_ZERO;
            adv_reg <= `SMRB_RST_ZERO;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `SMRB_OFF_MASK: mask_reg <= wdata_i;
                `SMRB_OFF_RATE: rate_reg <= wdata_i;
                `SMRB_OFF_CHOFF: off_reg <= wdata_i;
                `SMRB_OFF_SLEEP: sleep_reg <= wdata_i;
                `SMRB_OFF_ADV: adv_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    // Limit bank: two bytes per channel, high then low.
    genvar g;
    generate
        for (g = 0; g < `SMRB_NLIM; g++)
        begin : g_lim
            always_ff @(posedge clk_i)
            begin
                if (clr_all)
                    lim_reg[g] <= `SMRB_RST_ZERO;
                else if (wr_i && addr_i == `SMRB_OFF_LIM_LO + 6'(g))
                    lim_reg[g] <= wdata_i;
            end
        end
        for (g = 0; g < `SMRB_NCH; g++)
        begin : g_pair
            assign lim_hi[g] = lim_reg[2 * g];
            assign lim_lo[g] = lim_reg[2 * g + 1];
        end
    endgenerate

    // Status flags are sticky; a new error wins over the read clear.
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
            stat_reg <= `SMRB_RST_ZERO;
        else if (stat_rd)
            stat_reg <= err;
        else
            stat_reg <= stat_reg | err;
    end

    // Not-ready stands until a channel 7 reading is first stored after start.
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
            not_ready_reg <= 1'b1;
        else if (res_bus.we && res_bus.idx == 3'h7)
            not_ready_reg <= 1'b0;
    end

    smrb_seq u_seq
    (
        .clk_i(clk_i),
        .clr_i(clr_all),
        .run_i(cfg_reg[`SMRB_CFG_START] && sleep_reg[0] == 1'b0),
        .hold_i(cfg_reg[`SMRB_CFG_ACLR]),
        .shot_i(shot_pulse),
        .off_i(off_reg),
        .lim_hi_i(lim_hi),
        .lim_lo_i(lim_lo),
        .sample_i(sample_i),
        .res(res_bus.src),
        .err_o(err),
        .busy_o(busy)
    );

    smrb_results u_res
    (
        .clk_i(clk_i),
        .clr_i(clr_all),
        .wr(res_bus.dst),
        .rd_idx_i(addr_i[2:0]),
        .rd_data_o(res_word)
    );

    // Read mux; unmapped and write-only offsets return zero.
    always_comb
    begin
        rdata_next = 16'h0000;
        if (addr_i >= `SMRB_OFF_LIM_LO && addr_i <= `SMRB_OFF_LIM_HI)
            rdata_next = {8'h00, lim_reg[4'(addr_i - `SMRB_OFF_LIM_LO)]};
        else if (addr_i >= `SMRB_OFF_RES_LO && addr_i <= `SMRB_OFF_RES_HI)
            rdata_next = res_word;
        else
        begin
            case (addr_i)
                `SMRB_OFF_CFG: rdata_next = {8'h00, cfg_reg};
                `SMRB_OFF_STAT: rdata_next = {8'h00, stat_reg};
                `SMRB_OFF_MASK: rdata_next = {8'h00, mask_reg};
                `SMRB_OFF_RATE: rdata_next = {8'h00, rate_reg};
                `SMRB_OFF_CHOFF: rdata_next = {8'h00, off_reg};
                `SMRB_OFF_SLEEP: rdata_next = {8'h00, sleep_reg};
                `SMRB_OFF_ADV: rdata_next = {8'h00, adv_reg};
                `SMRB_OFF_BUSY: rdata_next = {14'h0000, not_ready_reg, busy};
                `SMRB_OFF_MAKER: rdata_next = {8'h00, MAKER_CODE};
                `SMRB_OFF_REV: rdata_next = {8'h00, REV_CODE};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // Read data is registered so it stands the cycle after the strobe.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
            rdata_o <= rdata_next;
    end

    // Alarm: unmasked flag, enabled, and not held clear.
    assign alarm_act = |(stat_reg & ~mask_reg)
        && cfg_reg[`SMRB_CFG_AEN]
        && !cfg_reg[`SMRB_CFG_ACLR];

    // Open-drain pin is registered to avoid glitches on the wire.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            alarm_oe_n_o <= 1'b1;
        else
            alarm_oe_n_o <= !alarm_act;
    end

    assign alarm_n_o = 1'b0;
    assign rate_o = rate_reg;
    assign deep_sleep_o = sleep_reg[0];
    assign adv_mode_o = adv_reg;

    a_init_self_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg_reg[`SMRB_CFG_INIT] |=> cfg_reg == `SMRB_RST_CFG)
        else $error("init bit did not restore config");
    a_alarm_gated: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !alarm_oe_n_o |-> $past(cfg_reg[`SMRB_CFG_AEN]))
        else $error("alarm driven while disabled");
    a_alarm_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $past(cfg_reg[`SMRB_CFG_ACLR]) |-> alarm_oe_n_o)
        else $error("alarm driven while clear bit set");
    a_clear_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg_reg[`SMRB_CFG_ACLR] && !stat_rd && !cfg_reg[`SMRB_CFG_INIT]
        |=> stat_reg == $past(stat_reg))
        else $error("status changed while loop halted");
    a_loop_halts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg_reg[`SMRB_CFG_ACLR] [*8] |-> !res_bus.we)
        else $error("loop kept running while clear bit set");
    a_mask_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ((stat_reg & ~mask_reg) == 8'h00) |=> alarm_oe_n_o)
        else $error("masked flag reached alarm");
    a_stat_rd_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stat_rd && !cfg_reg[`SMRB_CFG_INIT] |=> stat_reg == $past(err))
        else $error("status read did not clear");
    a_busy_reset: assert property (@(posedge clk_i)
        $past(sys_rst_i) |-> not_ready_reg && !busy)
        else $error("busy status not at default after reset");
    a_id_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `SMRB_OFF_MAKER |=> rdata_o == {8'h00, MAKER_CODE})
        else $error("maker code read wrong");
endmodule

/* tb/smrb_sense_model.sv */
// Converter front-end model that supplies the channel readings.
`timescale 1ns/1ps
module smrb_sense_model
(
    output logic [15:0] sample_o [8]
);
    // Each reading starts mid-scale so that a 0x00 to 0xff window does not trip.
    initial
    begin
        for (int c = 0; c < 8; c++)
        begin
            sample_o[c] = 16'h0800 + 16'(c);
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the monitor register bank.
`timescale 1ns/1ps
module testbench;
    import smrb_pkg::*;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
    localparam logic [7:0] REV = 8'h3c; // Arbitrary value.
    logic clk_i;
    logic sys_rst_i;
    logic wr_i;
    logic rd_i;
    smrb_addr_t addr_i;
    smrb_byte_t wdata_i;
    smrb_word_t rdata_o;
    logic [15:0] sample [8];
    logic alarm_n_o;
    logic alarm_oe_n_o;
    logic [7:0] rate_o;
    logic deep_sleep_o;
    logic [7:0] adv_mode_o;
    wire alarm_line;
    int fails;
    int tests_run;

    // The alarm pin is open drain with a pull-up on the board.
    assign alarm_line = alarm_oe_n_o ? 1'b1 : alarm_n_o;

    smrb_sense_model i_sense (.sample_o(sample));

    smrb_top #(.MAKER_CODE(MAKER), .REV_CODE(REV)) i_dut
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .rdata_o(rdata_o),
        .sample_i(sample),
        .alarm_n_o(alarm_n_o),
        .alarm_oe_n_o(alarm_oe_n_o),
        .rate_o(rate_o),
        .deep_sleep_o(deep_sleep_o),
        .adv_mode_o(adv_mode_o)
    );

    // Free-running 100 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk_word(input smrb_word_t g, input smrb_word_t e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: alarm pin %b", $time, g);
        end
    endtask

    // Strobes last one cycle, so back-to-back calls leave a gap.
    task automatic wr(input smrb_addr_t a, input smrb_byte_t d);
        @(negedge clk_i);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask

    task automatic rd(input smrb_addr_t a);
        @(negedge clk_i);
        rd_i = 1'b1;
        addr_i = a;
        @(negedge clk_i);
        rd_i = 1'b0;
    endtask

    // Read data is registered, so it is settled one edge later.
    task automatic rd_chk(input smrb_addr_t a, input smrb_word_t e);
        rd(a);
        chk_word(rdata_o, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence of register accesses.
    initial
    begin
        fails = 0;
        tests_run = 0;
        sys_rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        idle(6);
        sys_rst_i = 1'b0;
        rd_chk(6'h00, 16'h0008);
        rd_chk(6'h01, 16'h0000);
        rd_chk(6'h03, 16'h0000);
        rd_chk(6'h07, 16'h0000);
        rd_chk(6'h08, 16'h0000);
        rd_chk(6'h0a, 16'h0000);
        rd_chk(6'h0b, 16'h0000);
        rd_chk(6'h0c, 16'h0002);
        rd_chk(6'h3e, {8'h00, MAKER});
        rd_chk(6'h3f, {8'h00, REV});
        wr(6'h07, 8'ha5);
        wr(6'h0b, 8'h5a);
        wr(6'h0a, 8'h01);
        wr(6'h03, 8'hc3);
        wr(6'h08, 8'h3c);
        chk_word({8'h00, rate_o}, 16'h00a5);
        chk_word({8'h00, adv_mode_o}, 16'h005a);
        chk_pin(deep_sleep_o, 1'b1);
        rd_chk(6'h03, 16'h00c3);
        rd_chk(6'h08, 16'h003c);
        rd_chk(6'h0a, 16'h0001);
        // Writes to read-only places and reserved bits must not stick.
        wr(6'h01, 8'hff);
        wr(6'h0c, 8'hff);
        wr(6'h3e, 8'hff);
        wr(6'h22, 8'hff);
        wr(6'h00, 8'h76);
        rd_chk(6'h01, 16'h0000);
        rd_chk(6'h0c, 16'h0002);
        rd_chk(6'h3e, {8'h00, MAKER});
        rd_chk(6'h22, 16'h0000);
        rd_chk(6'h00, 16'h0002);
        wr(6'h0a, 8'h00);
        wr(6'h03, 8'h00);
        wr(6'h08, 8'h00);
        // Wide-open windows everywhere, then channel 2 high limit low.
        for (int c = 0; c < 8; c++)
        begin
            wr(6'h2a + 6'(2 * c), 8'hff);
            wr(6'h2b + 6'(2 * c), 8'h00);
        end
        wr(6'h2e, 8'h40);
        rd_chk(6'h2e, 16'h0040);
        rd_chk(6'h2f, 16'h0000);
        wr(6'h00, 8'h03);
        idle(300);
        chk_pin(alarm_line, 1'b0);
        wr(6'h00, 8'h0b);
        idle(20);
        chk_pin(alarm_line, 1'b1);
        rd_chk(6'h01, 16'h0004);
        idle(300);
        rd_chk(6'h01, 16'h0000);
        for (int c = 0; c < 8; c++)
        begin
            rd_chk(6'h20 + 6'(c), 16'h0800 + 16'(c));
        end
        rd_chk(6'h0c, 16'h0000);
        // A masked flag is recorded but keeps the pin released.
        wr(6'h03, 8'h04);
        wr(6'h00, 8'h03);
        idle(300);
        chk_pin(alarm_line, 1'b1);
        rd_chk(6'h01, 16'h0004);
        wr(6'h03, 8'h00);
        wr(6'h00, 8'h01);
        idle(300);
        chk_pin(alarm_line, 1'b1);
        // Single passes with the loop stopped.
        wr(6'h00, 8'h00);
        idle(100);
        rd(6'h01);
        wr(6'h09, 8'h01);
        idle(300);
        rd_chk(6'h01, 16'h0004);
        wr(6'h08, 8'h04);
        wr(6'h09, 8'h01);
        idle(300);
        rd_chk(6'h01, 16'h0000);
        // Restore defaults and see the bit fall back.
        wr(6'h00, 8'h80);
        idle(3);
        rd_chk(6'h00, 16'h0008);
        rd_chk(6'h08, 16'h0000);
        rd_chk(6'h2e, 16'h0000);
        rd_chk(6'h20, 16'h0000);
        rd_chk(6'h0c, 16'h0002);
        wrap_up();
    end

    // The sequence needs well under 5000 cycles; stop a hang.
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule
